//--- hdl/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
    // Command codes carried in the top nibble of each word
    localparam logic [3:0] CMD_WRITE_INPUT  = 4'h1;
    localparam logic [3:0] CMD_UPDATE_DAC   = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_POWERDOWN    = 4'h4;
    localparam logic [3:0] CMD_STROBE_MASK  = 4'h5;
    localparam logic [3:0] CMD_SOFT_RESET   = 4'h6;
    localparam logic [3:0] CMD_REF_SETUP    = 4'h7;
    // Field positions inside the 24-bit command word
    localparam int CMD_MSB  = 23;
    localparam int CMD_LSB  = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 0;
    localparam int MASK_MSB = 3;
    localparam int REF_BIT  = 0;
    // Channel and data widths
    localparam int NUM_CHANNELS = 8;
    localparam int DATA_WIDTH   = 16;
    // Power-down mode encodings
    localparam logic [1:0] PD_NORMAL   = 2'h0;
    localparam logic [1:0] PD_GROUND1K = 2'h1;
    localparam logic [1:0] PD_TRISTATE = 2'h3;
    // Reset values
    localparam logic [3:0]  STROBE_MASK_RESET = 4'h0;
    localparam logic        REF_SETUP_RESET   = 1'h0;
    localparam logic [15:0] ZERO_SCALE        = 16'h0000;
    localparam logic [15:0] MID_SCALE         = 16'h8000;
    // Timing
    localparam int CLOCK_MHZ          = 200;
    localparam int RECOVERY_NS        = 2500;
    localparam int RECOVERY_CYCLES    = (RECOVERY_NS * CLOCK_MHZ + 999) / 1000;
    localparam int RESET_MIN_NS       = 2000;
    localparam int RESET_MIN_CYCLES   = (RESET_MIN_NS * CLOCK_MHZ + 999) / 1000;
    localparam int POR_CYCLES         = 16;

    // Decoded command word from the serial front end
    typedef struct packed {
        logic [3:0]  command;
        logic [3:0]  address;
        logic [15:0] data;
    } command_word_t;

    // State of one channel output stage
    typedef struct packed {
        logic        valid;
        logic [1:0]  mode;
    } output_state_t;
endpackage

//--- hdl/channel_recovery.sv
`timescale 1ns/1ps
// Per-channel settling counter after leaving power-down
module channel_recovery #(
    parameter int CYCLES = dac_ctrl_pkg::RECOVERY_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [1:0] mode,
    output logic            settled
);
    logic [11:0] count;
    logic        wasDown;

    // Count down after a return to normal mode
    always_ff @(posedge clock) begin
        if (reset) begin
            count   <= 12'h000;
            wasDown <= 1'b0;
            settled <= 1'b1;
        end else begin
            wasDown <= (mode != dac_ctrl_pkg::PD_NORMAL);
            if (mode != dac_ctrl_pkg::PD_NORMAL) begin
                count   <= 12'h000;
                settled <= 1'b0;
            end else if (wasDown) begin
                count   <= 12'(CYCLES - 1);
                settled <= 1'b0;
            end else if (count != 12'h000) begin
                count <= count - 12'h001;
            end else begin
                settled <= 1'b1; // RL6
            end
        end
    end

    a_recovery_wait: assert property (@(posedge clock) disable iff (reset)
        $fell(mode != dac_ctrl_pkg::PD_NORMAL) |-> !settled [*8]) // RL6
        else $error("settled too early after power-down");
endmodule

//--- hdl/octal_dac_update_control.sv
`timescale 1ns/1ps
// What this block does
// RL1 - Command 0100 sets two power-down mode bits per channel.
// RL2 - Mode 00 means channel runs normally, amplifier drives output.
// RL3 - Mode 01 grounds output through 1k; mode 11 tristates it.
// RL4 - Channel 7 in top two bits down to channel 0; ignore DB18-16.
// RL5 - Power-down keeps DAC registers, and they still accept updates.
// RL6 - Leaving power-down waits 2.5 us before output is valid.
// RL7 - Each channel has an input register and a DAC register.
// RL8 - Command 0001 with strobe low updates input and DAC registers.
// RL9 - Strobe high: input only; later falling edge copies unmasked channels.
// RL10 - Command 0010 copies selected inputs to DAC registers, any strobe.
// RL11 - Command 0011 writes input and DAC registers, any strobe.
// RL12 - Command 0101 loads the 4-bit strobe mask; address ignored.
// RL13 - Mask resets to 0; mask 1 makes channel see strobe as high.
// RL14 - Strobe permanently low ignores mask and updates transparently.
// RL15 - Reset pin clears outputs to zero or midscale by select pin.
// RL16 - Reset blocks updates; cleared value holds until reprogrammed.
// RL17 - Command 0110 returns the DAC to its power-on reset code.
// RL18 - Strobe and reset pin activity is ignored during power-on reset.
// RL19 - Power-up level is zero scale or midscale by select pin.
// RL20 - Command 0111 DB0 sets reference off when 1, on when 0.
// RL21 - Command 0001 writes input registers of addressed channels.
// RL22 - Master sends command byte, then high byte, then low byte.
// RL23 - Undefined command codes change nothing.
module octal_dac_update_control #(
    parameter int CHANNELS = dac_ctrl_pkg::NUM_CHANNELS,
    parameter int WIDTH    = dac_ctrl_pkg::DATA_WIDTH,
    parameter int POR      = dac_ctrl_pkg::POR_CYCLES
) (
    input  wire logic                        clock,
    input  wire logic                        reset,
    input  wire dac_ctrl_pkg::command_word_t commandWord,
    input  wire logic                        commandValid,
    input  wire logic                        load_strobe_n,
    input  wire logic                        hardReset_n,
    input  wire logic                        reset_level_select,
    output logic [CHANNELS*WIDTH-1:0]        channel_output,
    output logic [CHANNELS-1:0]              powerdown_mode_hi,
    output logic [CHANNELS-1:0]              powerdown_mode_lo,
    output logic [CHANNELS-1:0]              outputValid,
    output logic [CHANNELS-1:0]              outputGround,
    output logic [CHANNELS-1:0]              outputTristate,
    output logic                             referenceOff
);
    logic [WIDTH-1:0]          inputReg [CHANNELS];
    logic [WIDTH-1:0]          dacReg   [CHANNELS];
    logic [1:0]                pdMode   [CHANNELS];
    logic [CHANNELS-1:0]       settled;
    logic [3:0]                strobeMask;
    logic                      strobeMeta, strobeSync, strobePrev;
    logic                      rstMeta, rstSync;
    logic                      selMeta, selSync;
    logic [7:0]                porCount;
    logic                      porActive;
    logic [11:0]               lowCount;
    logic                      strobeTied;
    logic                      strobeFall;
    logic                      clearActive;
    logic [WIDTH-1:0]          clearCode;

    // Mask bit for channel: four bits cover eight channels in pairs
    function automatic logic maskFor(input logic [3:0] m, input int ch);
        return m[ch % 4];
    endfunction

    // Two-flop synchronisers for pins
    always_ff @(posedge clock) begin
        if (reset) begin
            strobeMeta <= 1'b1;
            strobeSync <= 1'b1;
            strobePrev <= 1'b1;
            rstMeta    <= 1'b1;
            rstSync    <= 1'b1;
            selMeta    <= 1'b0;
            selSync    <= 1'b0;
        end else begin
            strobeMeta <= load_strobe_n;
            strobeSync <= strobeMeta;
            strobePrev <= strobeSync;
            rstMeta    <= hardReset_n;
            rstSync    <= rstMeta;
            selMeta    <= reset_level_select;
            selSync    <= selMeta;
        end
    end

    // Power-on reset interval
    always_ff @(posedge clock) begin
        if (reset) begin
            porCount  <= 8'(POR);
            porActive <= 1'b1;
        end else if (porCount != 8'h00) begin
            porCount <= porCount - 8'h01;
        end else begin
            porActive <= 1'b0;
        end
    end

    // Strobe held low a long time counts as tied low
    always_ff @(posedge clock) begin
        if (reset) begin
            lowCount   <= 12'h000;
            strobeTied <= 1'b0;
        end else if (strobeSync) begin
            lowCount   <= 12'h000;
            strobeTied <= 1'b0;
        end else if (lowCount != 12'hFFF) begin
            lowCount <= lowCount + 12'h001;
        end else begin
            strobeTied <= 1'b1; // RL14
        end
    end

    assign strobeFall  = strobePrev && !strobeSync && !porActive; // RL18
    assign clearActive = !rstSync && !porActive; // RL18
    assign clearCode   = selSync ? dac_ctrl_pkg::MID_SCALE
                                 : dac_ctrl_pkg::ZERO_SCALE; // RL15 RL19

    // Mask and reference registers
    always_ff @(posedge clock) begin
        if (reset) begin
            strobeMask   <= dac_ctrl_pkg::STROBE_MASK_RESET; // RL13
            referenceOff <= dac_ctrl_pkg::REF_SETUP_RESET;
        end else if (commandValid) begin // RL23
            // Codes outside the table match no branch and change nothing
            if (commandWord.command == dac_ctrl_pkg::CMD_STROBE_MASK)
                strobeMask <= commandWord.data[dac_ctrl_pkg::MASK_MSB:0]; // RL12
            if (commandWord.command == dac_ctrl_pkg::CMD_REF_SETUP)
                referenceOff <= commandWord.data[dac_ctrl_pkg::REF_BIT]; // RL20
            if (commandWord.command == dac_ctrl_pkg::CMD_SOFT_RESET) begin
                strobeMask   <= dac_ctrl_pkg::STROBE_MASK_RESET; // RL17
                referenceOff <= dac_ctrl_pkg::REF_SETUP_RESET;
            end
        end
    end

    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
            logic addressed;
            logic effLow;
            assign addressed = commandWord.address[ch % 4] ||
                               (commandWord.address == 4'(ch));
            // Channel sees strobe as high if masked, unless pin tied low
            assign effLow = !strobeSync &&
                            (strobeTied || !maskFor(strobeMask, ch)); // RL13

            // Input and DAC registers
            always_ff @(posedge clock) begin
                if (reset) begin
                    inputReg[ch] <= dac_ctrl_pkg::ZERO_SCALE;
                    dacReg[ch]   <= dac_ctrl_pkg::ZERO_SCALE;
                end else if (porActive) begin
                    inputReg[ch] <= clearCode; // RL19
                    dacReg[ch]   <= clearCode;
                end else if (clearActive) begin
                    inputReg[ch] <= clearCode; // RL15
                    dacReg[ch]   <= clearCode; // RL16
                end else if (commandValid && (commandWord.command ==
                             dac_ctrl_pkg::CMD_SOFT_RESET)) begin
                    inputReg[ch] <= clearCode; // RL17
                    dacReg[ch]   <= clearCode;
                end else if (commandValid && addressed && (commandWord.command
                             == dac_ctrl_pkg::CMD_WRITE_INPUT)) begin
                    inputReg[ch] <= commandWord.data; // RL21 RL7
                    if (effLow)
                        dacReg[ch] <= commandWord.data; // RL8
                end else if (commandValid && addressed && (commandWord.command
                             == dac_ctrl_pkg::CMD_UPDATE_DAC)) begin
                    dacReg[ch] <= inputReg[ch]; // RL10
                end else if (commandValid && addressed && (commandWord.command
                             == dac_ctrl_pkg::CMD_WRITE_UPDATE)) begin
                    inputReg[ch] <= commandWord.data; // RL11
                    dacReg[ch]   <= commandWord.data;
                end else if (strobeFall && !maskFor(strobeMask, ch)) begin
                    dacReg[ch] <= inputReg[ch]; // RL9
                end
            end

            // Power-down mode, independent of DAC register contents
            always_ff @(posedge clock) begin
                if (reset || porActive) begin
                    pdMode[ch] <= dac_ctrl_pkg::PD_NORMAL;
                end else if (commandValid && (commandWord.command ==
                             dac_ctrl_pkg::CMD_SOFT_RESET)) begin
                    pdMode[ch] <= dac_ctrl_pkg::PD_NORMAL;
                end else if (commandValid && (commandWord.command ==
                             dac_ctrl_pkg::CMD_POWERDOWN)) begin
                    pdMode[ch] <= commandWord.data[2*ch +: 2]; // RL1 RL4
                end
            end

            channel_recovery #(
                .CYCLES (dac_ctrl_pkg::RECOVERY_CYCLES)
            ) u_recovery (
                .clock   (clock),
                .reset   (reset),
                .mode    (pdMode[ch]),
                .settled (settled[ch])
            );

            // Registered output stage
            always_ff @(posedge clock) begin
                if (reset) begin
                    channel_output[ch*WIDTH +: WIDTH] <= '0;
                    powerdown_mode_hi[ch] <= 1'b0;
                    powerdown_mode_lo[ch] <= 1'b0;
                    outputValid[ch]       <= 1'b0;
                    outputGround[ch]      <= 1'b0;
                    outputTristate[ch]    <= 1'b0;
                end else begin
                    channel_output[ch*WIDTH +: WIDTH] <= dacReg[ch]; // RL5
                    powerdown_mode_hi[ch] <= pdMode[ch][1];
                    powerdown_mode_lo[ch] <= pdMode[ch][0];
                    outputValid[ch]    <= (pdMode[ch] ==
                                           dac_ctrl_pkg::PD_NORMAL) &&
                                          settled[ch]; // RL2 RL6
                    outputGround[ch]   <= (pdMode[ch] ==
                                           dac_ctrl_pkg::PD_GROUND1K); // RL3
                    outputTristate[ch] <= (pdMode[ch] ==
                                           dac_ctrl_pkg::PD_TRISTATE); // RL3
                end
            end

            a_cmd3_write: assert property (@(posedge clock) disable iff (reset)
                commandValid && addressed && !porActive && !clearActive &&
                commandWord.command == dac_ctrl_pkg::CMD_WRITE_UPDATE
                |=> ##1 channel_output[ch*WIDTH +: WIDTH] ==
                    $past(commandWord.data, 2)) // RL11
                else $error("write and update did not reach output");
            a_reset_hold: assert property (@(posedge clock) disable iff (reset)
                clearActive |=> ##1 channel_output[ch*WIDTH +: WIDTH] ==
                    $past(clearCode, 2)) // RL16
                else $error("output not cleared during reset");
            a_masked_fall: assert property (@(posedge clock)
                disable iff (reset)
                strobeFall && maskFor(strobeMask, ch) && !commandValid &&
                !clearActive |=> $stable(dacReg[ch])) // RL13
                else $error("masked channel followed strobe edge");
            a_ground_mode: assert property (@(posedge clock)
                disable iff (reset)
                pdMode[ch] == dac_ctrl_pkg::PD_GROUND1K |=>
                outputGround[ch] && !outputValid[ch]) // RL3
                else $error("ground mode not shown");
        end
    endgenerate

    a_mask_load: assert property (@(posedge clock) disable iff (reset)
        commandValid && commandWord.command == dac_ctrl_pkg::CMD_STROBE_MASK
        |=> strobeMask == $past(commandWord.data[3:0])) // RL12
        else $error("mask not loaded");
    a_ref_set: assert property (@(posedge clock) disable iff (reset)
        commandValid && commandWord.command == dac_ctrl_pkg::CMD_REF_SETUP
        |=> referenceOff == $past(commandWord.data[0])) // RL20
        else $error("reference bit not set");
    a_pd_load: assert property (@(posedge clock) disable iff (reset)
        commandValid && !porActive &&
        commandWord.command == dac_ctrl_pkg::CMD_POWERDOWN
        |=> ##1 powerdown_mode_hi[7] == $past(commandWord.data[15], 2)) // RL4
        else $error("channel 7 mode not from top bits");
    a_undef_cmd: assert property (@(posedge clock) disable iff (reset)
        commandValid && commandWord.command > dac_ctrl_pkg::CMD_REF_SETUP
        |=> $stable(strobeMask) && $stable(referenceOff)) // RL23
        else $error("undefined command changed state");
    a_por_ignore: assert property (@(posedge clock) disable iff (reset)
        porActive |-> !strobeFall && !clearActive) // RL18
        else $error("pin activity seen during power-on");
    // Channel 0 written while its strobe is effectively low
    a_transparent_write: assert property (@(posedge clock)
        disable iff (reset)
        commandValid && !porActive && !clearActive &&
        commandWord.command == dac_ctrl_pkg::CMD_WRITE_INPUT &&
        commandWord.address == 4'h0 && !strobeSync &&
        (strobeTied || !strobeMask[0])
        |=> dacReg[0] == $past(commandWord.data)) // RL8
        else $error("transparent write missed DAC register");
    // Update command copies input to DAC and keeps the input register
    a_update_copy: assert property (@(posedge clock) disable iff (reset)
        commandValid && !porActive && !clearActive &&
        commandWord.command == dac_ctrl_pkg::CMD_UPDATE_DAC &&
        commandWord.address == 4'h0
        |=> dacReg[0] == $past(inputReg[0]) && $stable(inputReg[0])) // RL10
        else $error("update command did not copy input register");
    // Channel 0 in any power-down mode never shows a valid output
    a_valid_mode: assert property (@(posedge clock) disable iff (reset)
        powerdown_mode_hi[0] || powerdown_mode_lo[0] |-> !outputValid[0]) // RL2
        else $error("powered-down channel shown as valid");

    c_strobe_fall: cover property (@(posedge clock) strobeFall);
    c_hard_reset: cover property (@(posedge clock) clearActive);
    c_powerdown: cover property (@(posedge clock) commandValid &&
        commandWord.command == dac_ctrl_pkg::CMD_POWERDOWN);
    c_tied_low: cover property (@(posedge clock) strobeTied);
    c_recovered: cover property (@(posedge clock) $rose(outputValid[1]));
endmodule

//--- verification/command_master.sv
`timescale 1ns/1ps
// Far-side master: frames command words, drives the strobe and reset pins
module command_master (
    input  wire logic                   clock,
    output dac_ctrl_pkg::command_word_t commandWord,
    output logic                        commandValid,
    output logic                        load_strobe_n,
    output logic                        hardReset_n
);
    // Idle pins at time zero
    initial begin
        commandWord   = '0;
        commandValid  = 1'b0;
        load_strobe_n = 1'b1;
        hardReset_n   = 1'b1;
    end

    // Command byte first, then high data byte, then low data byte
    task automatic send(input logic [7:0] cmdByte, input logic [7:0] hiByte,
                        input logic [7:0] loByte);
        @(posedge clock);
        commandWord  <= {cmdByte, hiByte, loByte};
        commandValid <= 1'b1;
        @(posedge clock);
        commandWord  <= ~{cmdByte, hiByte, loByte}; // Released word is junk
        commandValid <= 1'b0;
    endtask

    // Power-down word: address top bit low, lower address bits as filler
    task automatic powerdown(input logic [15:0] modes);
        send({dac_ctrl_pkg::CMD_POWERDOWN, 4'h7}, modes[15:8], modes[7:0]);
    endtask

    // Strobe level held by the caller
    task automatic strobe_level(input logic level);
        @(posedge clock);
        load_strobe_n <= level;
    endtask

    // Short low pulse, only after the last word has been sent
    task automatic strobe_pulse();
        @(posedge clock);
        load_strobe_n <= 1'b0;
        repeat (4) @(posedge clock);
        load_strobe_n <= 1'b1;
    endtask

    // Reset pin held low beyond its minimum width
    task automatic hard_reset();
        @(posedge clock);
        hardReset_n <= 1'b0;
        repeat (dac_ctrl_pkg::RESET_MIN_CYCLES + 8) @(posedge clock);
        hardReset_n <= 1'b1;
    endtask
endmodule

//--- verification/octal_dac_update_control_bench.sv
`timescale 1ns/1ps
// Bench for the octal DAC command and update control
module octal_dac_update_control_bench;
    logic                        clock;
    logic                        reset;
    logic                        reset_level_select;
    dac_ctrl_pkg::command_word_t commandWord;
    logic                        commandValid;
    logic                        load_strobe_n;
    logic                        hardReset_n;
    logic [127:0]                channel_output;
    logic [7:0]                  powerdown_mode_hi;
    logic [7:0]                  powerdown_mode_lo;
    logic [7:0]                  outputValid;
    logic [7:0]                  outputGround;
    logic [7:0]                  outputTristate;
    logic                        referenceOff;
    int                          num_errors;
    int                          n_tests;

    octal_dac_update_control i_octal_dac_update_control (
        .clock(clock), .reset(reset), .commandWord(commandWord),
        .commandValid(commandValid), .load_strobe_n(load_strobe_n),
        .hardReset_n(hardReset_n), .reset_level_select(reset_level_select),
        .channel_output(channel_output),
        .powerdown_mode_hi(powerdown_mode_hi),
        .powerdown_mode_lo(powerdown_mode_lo), .outputValid(outputValid),
        .outputGround(outputGround), .outputTristate(outputTristate),
        .referenceOff(referenceOff));

    command_master i_command_master (
        .clock(clock), .commandWord(commandWord),
        .commandValid(commandValid), .load_strobe_n(load_strobe_n),
        .hardReset_n(hardReset_n));

    // Free-running 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Compares one value and counts it
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] expv);
        n_tests++;
        if (seen !== expv) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, expv, seen);
        end
    endtask

    // Waits whole cycles, then steps off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // One command, returns once its outputs have landed
    task automatic cmd(input logic [3:0] code, input logic [3:0] addr,
                       input logic [15:0] data);
        i_command_master.send({code, addr}, data[15:8], data[7:0]);
        tick(2);
    endtask

    function automatic logic [15:0] chan(input int ch);
        return channel_output[16*ch +: 16];
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        num_errors = 0;
        n_tests = 0;
        reset = 1'b1;
        reset_level_select = 1'b1;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        tick(24);
        for (int ch = 0; ch < 8; ch++)
            check("powerup", chan(ch), 16'h8000);
        check("ref on", {15'h0, referenceOff}, 16'h0000);
        $display("test powerup done");
        // Strobe held low: write goes straight through
        i_command_master.strobe_level(1'b0);
        tick(6);
        cmd(dac_ctrl_pkg::CMD_WRITE_INPUT, 4'h0, 16'h1234);
        check("transparent ch0", chan(0), 16'h1234);
        check("other ch1", chan(1), 16'h8000);
        i_command_master.strobe_level(1'b1);
        tick(6);
        // Strobe high: deferred update, mask on channels 2 and 6
        cmd(dac_ctrl_pkg::CMD_WRITE_INPUT, 4'h8, 16'hABCD);
        cmd(dac_ctrl_pkg::CMD_WRITE_INPUT, 4'h4, 16'h5555);
        check("deferred ch3", chan(3), 16'h8000);
        cmd(dac_ctrl_pkg::CMD_STROBE_MASK, 4'h7, 16'h0004);
        i_command_master.strobe_pulse();
        tick(8);
        check("pulse ch7", chan(7), 16'hABCD);
        check("pulse ch4", chan(4), 16'h5555);
        check("masked ch6", chan(6), 16'h8000);
        cmd(dac_ctrl_pkg::CMD_UPDATE_DAC, 4'h4, 16'h0000);
        check("update ch6", chan(6), 16'h5555);
        cmd(dac_ctrl_pkg::CMD_WRITE_UPDATE, 4'h0, 16'h0F0F);
        check("write update ch0", chan(0), 16'h0F0F);
        $display("test strobe done");
        // Undefined codes change nothing
        for (int c = 0; c < 16; c++)
            if (c == 0 || c > 7)
                cmd(4'(c), 4'hF, 16'hFFFF);
        check("undef ch0", chan(0), 16'h0F0F);
        check("undef pd", {8'h00, powerdown_mode_lo}, 16'h0000);
        check("undef ref", {15'h0, referenceOff}, 16'h0000);
        // Strobe tied low overrides the mask
        i_command_master.strobe_level(1'b0);
        tick(4100);
        cmd(dac_ctrl_pkg::CMD_WRITE_INPUT, 4'h4, 16'h7777);
        check("tied low ch6", chan(6), 16'h7777);
        i_command_master.strobe_level(1'b1);
        tick(6);
        $display("test mask done");
        // Channel 7 tristate, channel 1 grounded
        i_command_master.powerdown(16'hC004);
        tick(2);
        check("pd hi", {8'h00, powerdown_mode_hi}, 16'h0080);
        check("pd lo", {8'h00, powerdown_mode_lo}, 16'h0082);
        check("ground", {8'h00, outputGround}, 16'h0002);
        check("tristate", {8'h00, outputTristate}, 16'h0080);
        check("valid", {8'h00, outputValid}, 16'h007D);
        cmd(dac_ctrl_pkg::CMD_WRITE_UPDATE, 4'h1, 16'h2222);
        check("pd write ch1", chan(1), 16'h2222);
        i_command_master.powerdown(16'h0000);
        tick(440);
        check("recovering", {15'h0, outputValid[1]}, 16'h0000);
        tick(80);
        check("recovered", {15'h0, outputValid[1]}, 16'h0001);
        $display("test powerdown done");
        // Reference bit, then software reset
        cmd(dac_ctrl_pkg::CMD_REF_SETUP, 4'h0, 16'h0001);
        check("ref off", {15'h0, referenceOff}, 16'h0001);
        cmd(dac_ctrl_pkg::CMD_REF_SETUP, 4'h0, 16'hFFFE);
        check("ref db0", {15'h0, referenceOff}, 16'h0000);
        cmd(dac_ctrl_pkg::CMD_REF_SETUP, 4'h0, 16'h0001);
        cmd(dac_ctrl_pkg::CMD_SOFT_RESET, 4'h0, 16'h0000);
        tick(24);
        for (int ch = 0; ch < 8; ch++)
            check("soft reset", chan(ch), 16'h8000);
        check("soft ref", {15'h0, referenceOff}, 16'h0000);
        $display("test soft reset done");
        // Reset pin clears to zero scale and blocks writes meanwhile
        @(posedge clock);
        reset_level_select <= 1'b0;
        fork
            i_command_master.hard_reset();
            begin
                tick(100);
                cmd(dac_ctrl_pkg::CMD_WRITE_UPDATE, 4'h0, 16'h3333);
            end
        join
        tick(6);
        for (int ch = 0; ch < 8; ch++)
            check("hard reset", chan(ch), 16'h0000);
        cmd(dac_ctrl_pkg::CMD_WRITE_UPDATE, 4'h0, 16'h3333);
        check("after reset ch0", chan(0), 16'h3333);
        check("after reset ch5", chan(5), 16'h0000);
        $display("test hard reset done");
        report_and_stop();
    end
endmodule
